//--- src/alux_top.sv
/*
  alux_top: executes subtract-with-borrow, nibble swap, xor and direction load.
  assumes the core supplies the addressed register value and stores reg_wr_data
  when reg_wr_en pulses; one operation per enabled cycle.
*/
// Operation
// (RULE_01) subtract-with-borrow gives register minus accumulator minus inverted carry, sets all three flags.
// (RULE_02) subtract-with-borrow result goes to accumulator when dest is 0, else to the register.
// (RULE_03) nibble swap exchanges the register's halves and touches no flag.
// (RULE_04) nibble swap result goes to accumulator when dest is 0, else to the register.
// (RULE_05) direction load copies accumulator to port A, B or C direction for operand 5, 6, 7.
// (RULE_06) xor literal puts accumulator xor literal in the accumulator, updating only zero.
// (RULE_07) xor register xors accumulator with register to the chosen dest, updating only zero.
// (RULE_08) the zero flag is set when the 8-bit result is zero and cleared otherwise.
`timescale 1ns/100ps
module alux_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic op_valid,
  input alux_pkg::alux_op_t op,
  input wire logic [alux_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic [7:0] literal,
  input wire logic dest_sel,
  output logic [7:0] accumulator,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output logic reg_wr_en,
  output logic [alux_pkg::ADDR_W-1:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction
);
  import alux_pkg::*;

  alux_core_if cif ();
  alux_compute u_compute (
    .cif(cif)
  );

  logic [7:0] dir_q [NUM_PORTS];
  logic [7:0] next_dir [NUM_PORTS];
  logic [7:0] next_accumulator;
  logic next_carry_flag;
  logic next_nibble_carry_flag;
  logic next_zero_flag;
  logic next_reg_wr_en;
  logic [ADDR_W-1:0] next_reg_wr_addr;
  logic [7:0] next_reg_wr_data;
  logic go;

  assign cif.op = op_valid ? op : ALUX_OP_NONE;
  assign cif.acc = accumulator;
  assign cif.reg_val = reg_rd_data;
  assign cif.lit = literal;
  assign cif.carry_in = carry_flag;
  assign go = clk_en && op_valid;

  always_comb begin
    next_accumulator = accumulator;
    next_carry_flag = carry_flag;
    next_nibble_carry_flag = nibble_carry_flag;
    next_zero_flag = zero_flag;
    next_reg_wr_en = 1'b0;
    next_reg_wr_addr = reg_wr_addr;
    next_reg_wr_data = reg_wr_data;
    if (op_valid) begin
      if (cif.upd_carry) begin
        next_carry_flag = cif.carry_out; // [RULE_01]
        next_nibble_carry_flag = cif.nib_carry_out;
      end
      if (cif.upd_zero) begin
        next_zero_flag = cif.zero_out; // [RULE_08]
      end
      unique case (op)
        ALUX_OP_SUB_BORROW, ALUX_OP_NIBBLE_SWAP, ALUX_OP_XOR_REG: begin
          if (dest_sel == DEST_REG) begin // [RULE_02] [RULE_04] [RULE_07]
            next_reg_wr_en = 1'b1;
            next_reg_wr_addr = reg_addr;
            next_reg_wr_data = cif.result;
          end else begin
            next_accumulator = cif.result;
          end
        end
        ALUX_OP_XOR_LIT: begin
          next_accumulator = cif.result; // [RULE_06]
        end
        ALUX_OP_DIR_LOAD, ALUX_OP_NONE: begin
          next_accumulator = accumulator;
        end
      endcase
    end
  end

  // invalid direction operands are dropped so no port changes by accident
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_dir
      always_comb begin
        next_dir[p] = dir_q[p];
        if (op_valid && op == ALUX_OP_DIR_LOAD &&
            reg_addr[2:0] == DIR_SEL_A + 3'(p) && reg_addr[6:3] == 4'h0) begin
          next_dir[p] = accumulator; // [RULE_05]
        end
      end
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          dir_q[p] <= DIR_RESET;
        end else if (clk_en) begin
          dir_q[p] <= next_dir[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accumulator <= ACC_RESET;
      carry_flag <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wr_addr <= '0;
      reg_wr_data <= 8'h00;
    end else if (clk_en) begin
      accumulator <= next_accumulator;
      carry_flag <= next_carry_flag;
      nibble_carry_flag <= next_nibble_carry_flag;
      zero_flag <= next_zero_flag;
      reg_wr_en <= next_reg_wr_en;
      reg_wr_addr <= next_reg_wr_addr;
      reg_wr_data <= next_reg_wr_data;
    end
  end

  assign port_a_direction = dir_q[0];
  assign port_b_direction = dir_q[1];
  assign port_c_direction = dir_q[2];

  property p_sub_value;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_SUB_BORROW && dest_sel == DEST_ACC) |=>
      accumulator == 8'($past(reg_rd_data) - $past(accumulator) - 8'(!$past(carry_flag)));
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("sub with borrow wrong"); // [RULE_01]

  property p_sub_dest;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_SUB_BORROW && dest_sel == DEST_REG) |=>
      reg_wr_en && reg_wr_addr == $past(reg_addr) && $stable(accumulator);
  endproperty
  a_sub_dest: assert property (p_sub_dest) else $error("sub dest wrong"); // [RULE_02]

  property p_swap_flags;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_NIBBLE_SWAP) |=>
      $stable(carry_flag) && $stable(zero_flag) && $stable(nibble_carry_flag);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap changed a flag"); // [RULE_03]

  property p_swap_reg;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_NIBBLE_SWAP && dest_sel == DEST_REG) |=>
      reg_wr_en && reg_wr_data == {$past(reg_rd_data[3:0]), $past(reg_rd_data[7:4])};
  endproperty
  a_swap_reg: assert property (p_swap_reg) else $error("swap to register wrong"); // [RULE_04]

  property p_dir_b;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_DIR_LOAD && reg_addr == 7'(DIR_SEL_B)) |=>
      port_b_direction == $past(accumulator) && $stable(port_a_direction) && $stable(zero_flag);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("direction load wrong"); // [RULE_05]

  property p_xor_lit;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_XOR_LIT) |=>
      accumulator == ($past(accumulator) ^ $past(literal)) && $stable(carry_flag);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong"); // [RULE_06]

  property p_xor_reg;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_XOR_REG && dest_sel == DEST_ACC) |=>
      accumulator == ($past(accumulator) ^ $past(reg_rd_data)) && !reg_wr_en;
  endproperty
  a_xor_reg: assert property (p_xor_reg) else $error("xor register wrong"); // [RULE_07]

  property p_zero;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_XOR_LIT) |=> zero_flag == (accumulator == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE_08]

  // flags judged as no-borrow comparisons, independent of the adder form
  property p_sub_flags;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_SUB_BORROW) |=>
      carry_flag == ({1'b0, $past(reg_rd_data)} >=
        {1'b0, $past(accumulator)} + {8'h00, !$past(carry_flag)}) &&
      nibble_carry_flag == ({1'b0, $past(reg_rd_data[3:0])} >=
        {1'b0, $past(accumulator[3:0])} + {4'h0, !$past(carry_flag)});
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("sub flags wrong"); // [RULE_01]

  property p_swap_acc;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_NIBBLE_SWAP && dest_sel == DEST_ACC) |=>
      accumulator == {$past(reg_rd_data[3:0]), $past(reg_rd_data[7:4])} && !reg_wr_en;
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to accumulator wrong"); // [RULE_04]

  property p_dir_invalid;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_DIR_LOAD &&
      (reg_addr < 7'(DIR_SEL_A) || reg_addr > 7'(DIR_SEL_C))) |=>
      $stable(port_a_direction) && $stable(port_b_direction) && $stable(port_c_direction);
  endproperty
  a_dir_invalid: assert property (p_dir_invalid) else $error("bad operand moved a port"); // [RULE_05]

  property p_xor_reg_dest;
    @(posedge ref_clk) disable iff (srst)
    (go && op == ALUX_OP_XOR_REG && dest_sel == DEST_REG) |=>
      reg_wr_en && reg_wr_data == ($past(accumulator) ^ $past(reg_rd_data)) &&
      $stable(accumulator) && $stable(carry_flag);
  endproperty
  a_xor_reg_dest: assert property (p_xor_reg_dest) else $error("xor to register wrong"); // [RULE_07]

  // write strobe is one enabled cycle wide, so the core stores each result once
  sequence s_write_taken;
    go && dest_sel == DEST_REG &&
      (op == ALUX_OP_SUB_BORROW || op == ALUX_OP_NIBBLE_SWAP || op == ALUX_OP_XOR_REG);
  endsequence
  sequence s_no_write_enabled;
    clk_en && !(op_valid && dest_sel == DEST_REG &&
      (op == ALUX_OP_SUB_BORROW || op == ALUX_OP_NIBBLE_SWAP || op == ALUX_OP_XOR_REG));
  endsequence
  property p_wr_pulse;
    @(posedge ref_clk) disable iff (srst)
    s_write_taken ##1 s_no_write_enabled |=> !reg_wr_en;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe held too long"); // [RULE_02]
endmodule // alux_top

//--- pkg/alux_pkg.sv
/*
  alux_pkg: shared constants and types for the sub/swap/xor/direction datapath.
  assumes a surrounding core that decodes instructions and owns the register file.
*/
package alux_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] REG_ADDR_MAX = 7'h7F;
  localparam logic [2:0] DIR_SEL_A = 3'h5;
  localparam logic [2:0] DIR_SEL_B = 3'h6;
  localparam logic [2:0] DIR_SEL_C = 3'h7;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  localparam int NUM_PORTS = 3;

  typedef enum logic [2:0] {
    ALUX_OP_NONE,
    ALUX_OP_SUB_BORROW,
    ALUX_OP_NIBBLE_SWAP,
    ALUX_OP_XOR_LIT,
    ALUX_OP_XOR_REG,
    ALUX_OP_DIR_LOAD
  } alux_op_t;
endpackage

//--- pkg/alux_core_if.sv
/*
  alux_core_if: operands and results between the top and its compute unit.
  assumes one clock domain; purely combinational traffic.
*/
`timescale 1ns/100ps
interface alux_core_if;
  import alux_pkg::*;
  alux_op_t op;
  logic [7:0] acc;
  logic [7:0] reg_val;
  logic [7:0] lit;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic nib_carry_out;
  logic zero_out;
  logic upd_carry;
  logic upd_zero;
  modport top (output op, acc, reg_val, lit, carry_in,
    input result, carry_out, nib_carry_out, zero_out, upd_carry, upd_zero);
  modport unit (input op, acc, reg_val, lit, carry_in,
    output result, carry_out, nib_carry_out, zero_out, upd_carry, upd_zero);
endinterface

//--- src/alux_compute.sv
/*
  alux_compute: combinational result and flag generation for one operation.
  assumes operands are stable for the cycle in which the top registers them.
*/
`timescale 1ns/100ps
module alux_compute (
  alux_core_if.unit cif
);
  import alux_pkg::*;

  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    // carry set means no borrow, so borrow in is its inverse
    diff = {1'b0, cif.reg_val} + {1'b0, ~cif.acc} + {8'h00, cif.carry_in}; // [RULE_01]
    ndiff = {1'b0, cif.reg_val[3:0]} + {1'b0, ~cif.acc[3:0]} + {4'h0, cif.carry_in};
    cif.result = 8'h00;
    cif.upd_carry = 1'b0;
    cif.upd_zero = 1'b0;
    unique case (cif.op)
      ALUX_OP_SUB_BORROW: begin
        cif.result = diff[7:0];
        cif.upd_carry = 1'b1;
        cif.upd_zero = 1'b1;
      end
      ALUX_OP_NIBBLE_SWAP: begin
        cif.result = {cif.reg_val[3:0], cif.reg_val[7:4]}; // [RULE_03]
      end
      ALUX_OP_XOR_LIT: begin
        cif.result = cif.acc ^ cif.lit; // [RULE_06]
        cif.upd_zero = 1'b1;
      end
      ALUX_OP_XOR_REG: begin
        cif.result = cif.acc ^ cif.reg_val; // [RULE_07]
        cif.upd_zero = 1'b1;
      end
      ALUX_OP_DIR_LOAD: begin
        cif.result = cif.acc;
      end
      ALUX_OP_NONE: begin
        cif.result = 8'h00;
      end
    endcase
    cif.carry_out = diff[8];
    cif.nib_carry_out = ndiff[4];
    cif.zero_out = (cif.result == 8'h00); // [RULE_08]
  end
endmodule // alux_compute

//--- sim/tb_top.sv
/*
  tb_top: self-checking bench for alux_top, with a reference model and a result queue.
  assumes the register file lives outside; the bench plays it via reg_rd_data.
*/
`timescale 1ns/100ps
module tb_top;
  import alux_pkg::*;
  logic ref_clk, srst, clk_en, op_valid, dest_sel, nibble_carry_flag, zero_flag;
  logic carry_flag, reg_wr_en;
  alux_op_t op;
  logic [6:0] reg_addr, reg_wr_addr;
  logic [7:0] reg_rd_data, literal, accumulator, reg_wr_data;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic [7:0] m_acc, m_wd, m_pa, m_pb, m_pc;
  logic [6:0] m_wa;
  logic m_c, m_dc, m_z, m_we;
  logic [50:0] note_q[$];
  logic [50:0] exp_v, act_v;
  int fail_count, total_checks, cycles, i;
  integer seed, k;
  alux_top i_alux_top (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .op_valid(op_valid),
    .op(op), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .literal(literal),
    .dest_sel(dest_sel), .accumulator(accumulator), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // model advances as the op is presented; the note waits for the taking edge
  task automatic run_op(input alux_op_t o, input logic [6:0] a, input logic [7:0] d, l,
      input logic ds, en);
    logic [8:0] t;
    logic [4:0] n;
    logic [7:0] r;
    logic to_dest;
    @(posedge ref_clk);
    op <= o; reg_addr <= a; reg_rd_data <= d; literal <= l; dest_sel <= ds;
    clk_en <= en; op_valid <= 1'b1;
    to_dest = 1'b0;
    r = 8'h00;
    if (en) begin // frozen state holds wr pulse too
      m_we = 1'b0;
      case (o)
        ALUX_OP_SUB_BORROW: begin
          t = {1'b0, d} - {1'b0, m_acc} - {8'h00, ~m_c};
          n = {1'b0, d[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, ~m_c};
          r = t[7:0]; m_c = ~t[8]; m_dc = ~n[4]; m_z = (r == 8'h00); to_dest = 1'b1;
        end
        ALUX_OP_NIBBLE_SWAP: begin r = {d[3:0], d[7:4]}; to_dest = 1'b1; end
        ALUX_OP_XOR_LIT: begin m_acc = m_acc ^ l; m_z = (m_acc == 8'h00); end
        ALUX_OP_XOR_REG: begin
          r = m_acc ^ d; m_z = (r == 8'h00); to_dest = 1'b1;
        end
        ALUX_OP_DIR_LOAD: begin
          if (a == 7'h05) m_pa = m_acc;
          if (a == 7'h06) m_pb = m_acc;
          if (a == 7'h07) m_pc = m_acc;
        end
        default: ;
      endcase
      if (to_dest && ds) begin m_we = 1'b1; m_wa = a; m_wd = r; end
      else if (to_dest) m_acc = r;
    end
    note_q.push_back({m_acc, m_c, m_dc, m_z, m_we, m_wa, m_wd, m_pa, m_pb, m_pc});
  endtask
  // write address and data only matter while the write pulse is up
  always @(posedge ref_clk) begin
    if (op_valid === 1'b1 && srst === 1'b0) begin
      #1;
      exp_v = note_q.pop_front();
      act_v = {accumulator, carry_flag, nibble_carry_flag, zero_flag, reg_wr_en, reg_wr_addr,
        reg_wr_data, port_a_direction, port_b_direction, port_c_direction};
      if (exp_v[39] !== 1'b1) begin exp_v[38:24] = '0; act_v[38:24] = '0; end
      total_checks++;
      if (act_v !== exp_v) begin
        fail_count++;
        $display("mismatch t=%0t got %h exp %h", $time, act_v, exp_v);
      end
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    seed = 51;
    srst = 1'b1; clk_en = 1'b1; op_valid = 1'b0; op = ALUX_OP_NONE; reg_addr = 7'h00;
    reg_rd_data = 8'h00; literal = 8'h00; dest_sel = 1'b0;
    m_acc = ACC_RESET; m_c = 1'b0; m_dc = 1'b0; m_z = 1'b0; m_we = 1'b0; m_wa = 7'h00;
    m_wd = 8'h00; m_pa = DIR_RESET; m_pb = DIR_RESET; m_pc = DIR_RESET;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    run_op(ALUX_OP_DIR_LOAD, 7'h04, 8'h00, 8'h00, 1'b0, 1'b1);
    for (i = 0; i < 3; i++) begin
      run_op(ALUX_OP_XOR_LIT, 7'h00, 8'h00, 8'h3C + 8'(i), 1'b0, 1'b1);
      run_op(ALUX_OP_DIR_LOAD, 7'h05 + 7'(i), 8'h00, 8'h00, 1'b0, 1'b1);
    end
    run_op(ALUX_OP_DIR_LOAD, 7'h0D, 8'h00, 8'h00, 1'b0, 1'b1);
    run_op(ALUX_OP_XOR_LIT, 7'h00, 8'h00, 8'h3F, 1'b0, 1'b1);
    run_op(ALUX_OP_SUB_BORROW, 7'h7F, 8'h00, 8'h00, 1'b1, 1'b1);
    run_op(ALUX_OP_SUB_BORROW, 7'h10, 8'h80, 8'h00, 1'b0, 1'b0);
    run_op(ALUX_OP_NIBBLE_SWAP, 7'h11, 8'h1E, 8'h00, 1'b1, 1'b1);
    // random mix, clock enable low about a quarter of the time
    for (i = 0; i < 400; i++) begin
      k = $random(seed);
      run_op((k[2:0] > 3'h5) ? ALUX_OP_SUB_BORROW : alux_op_t'(k[2:0]),
        k[10] ? (7'h05 + 7'(k[12:11])) : 7'(k[9:3]), 8'(k[20:13]), 8'(k[28:21]), k[29],
        k[31:30] != 2'b00);
    end
    @(posedge ref_clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule // tb_top
